// ### core/adcsq_pkg.sv
// Purpose: Shared constants, states and decode helpers of the converter sequencer.
// Assumes: 100 MHz core clock, 8-bit registers on a 3-bit register address.
// Notes:   All resets of control registers are zero.
package adcsq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int         ADDR_W          = 3;
  localparam logic [2:0] OFS_CTRL_ZERO   = 3'h0;
  localparam logic [2:0] OFS_CTRL_ONE    = 3'h1;
  localparam logic [2:0] OFS_CTRL_TWO    = 3'h2;
  localparam logic [2:0] OFS_RESULT_HIGH = 3'h3;
  localparam logic [2:0] OFS_RESULT_LOW  = 3'h4;
  localparam logic [2:0] OFS_DONE_STATUS = 3'h5;

  localparam int BIT_ENABLE     = 0;
  localparam int BIT_GO         = 1;
  localparam int POS_CHANNEL    = 2;
  localparam int POS_PORT_CFG   = 0;
  localparam int BIT_POS_REF    = 4;
  localparam int BIT_NEG_REF    = 5;
  localparam int POS_CLK_SEL    = 0;
  localparam int POS_ACQ_SEL    = 3;
  localparam int BIT_JUSTIFY    = 7;
  localparam int BIT_DONE_FLAG  = 0;
  localparam int BIT_IRQ_ENABLE = 1;

  localparam logic [7:0] RST_CTRL_ZERO   = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE    = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO    = 8'h00;
  localparam logic [1:0] RST_DONE_STATUS = 2'h0;

  localparam logic [3:0] LAST_CHANNEL = 4'hA;
  localparam logic [9:0] FULL_SCALE   = 10'h3FF;
  localparam logic [9:0] SAR_FIRST    = 10'h200;

  ////////////////////////////////////////////////////////////////////////////
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         INSTR_CYCLE_NS = 40;
  localparam int         RC_HOLD_CNT    = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RC_HOLD_CLKS   = 5'(RC_HOLD_CNT);
  localparam logic [4:0] RECOVER_TADS   = 5'h02;
  localparam logic [4:0] CONV_LAST_TAD  = 5'h0A;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011,
    ST_WAIT  = 3'b100
  } adcsq_state_e;

  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      3'h7:    acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction

  function automatic logic [6:0] core_div(input logic [2:0] sel);
    case (sel)
      3'h0:    core_div = 7'h02;
      3'h1:    core_div = 7'h08;
      3'h2:    core_div = 7'h20;
      3'h4:    core_div = 7'h04;
      3'h5:    core_div = 7'h10;
      3'h6:    core_div = 7'h40;
      default: core_div = 7'h00;
    endcase
  endfunction

  function automatic logic is_rc(input logic [2:0] sel);
    is_rc = (sel[1:0] == 2'b11);
  endfunction

endpackage

// ### core/adcsq_tad_tick.sv
// Purpose: Makes one-cycle conversion bit period ticks from the core clock or the RC clock.
// Assumes: The RC clock pin is asynchronous and much slower than the core clock.
// Notes:   Core-derived ticks stop in sleep; RC ticks keep running.
module adcsq_tad_tick
  import adcsq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [2:0] clk_sel_in,
  input  wire logic       run_in,
  input  wire logic       sleep_in,
  input  wire logic       rc_clk_in,
  output logic            tick_out
);

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       rc_meta;
  logic       rc_sync;
  logic       rc_last;
  logic       next_tick;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cnt  = 7'h00;
    next_tick = 1'b0;
    if (run_in) begin
      if (is_rc(clk_sel_in)) begin
        next_tick = rc_sync & ~rc_last;
      end else if (!sleep_in) begin
        if (cnt == core_div(clk_sel_in) - 7'h01) begin
          next_tick = 1'b1;
        end else begin
          next_cnt = cnt + 7'h01;
        end
      end else begin
        next_cnt = cnt;
      end
    end
  end

  // Counter clears while idle so each period is whole from the start.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt      <= 7'h00;
      rc_meta  <= 1'b0;
      rc_sync  <= 1'b0;
      rc_last  <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      rc_meta  <= rc_clk_in;
      rc_sync  <= rc_meta;
      rc_last  <= rc_sync;
      tick_out <= next_tick;
    end
  end

endmodule

// ### core/adcsq_sequencer.sv
// Purpose: Register file and acquire/convert sequencer of a 10-bit SAR converter.
// Assumes: Comparator pin is high when the held input is at or above the DAC level.
// Notes:
// Notes on behaviour
// RULE1 - Justify bit one gives right justified result, zero gives left justified.
// RULE2 - Acquisition field picks 0,2,4,6,8,12,16,20 bit periods.
// RULE3 - Clock field picks core/2,/8,/32,/4,/16,/64; codes 011 and 111 pick RC.
// RULE4 - With RC clock, hold off the bit clock one instruction cycle after start.
// RULE5 - References are software selectable: supply rails or the reference pins.
// RULE6 - Conversions run in sleep only with the RC clock selected.
// RULE7 - Result comes from successive approximation on the held sample.
// RULE8 - Reset restores registers, turns the converter off, aborts any conversion.
// RULE9 - On completion load result, clear go, set the done flag.
// RULE10 - Power-on reset leaves the result pair untouched.
// RULE11 - Wait at least two bit periods after a conversion before acquiring again.
// RULE12 - Acquisition field zero: go stops sampling at once and converts.
// RULE13 - Nonzero acquisition field: sample the programmed periods, then convert.
// RULE14 - After completion, sampling of the selected channel resumes by itself.
// RULE15 - Go stays set through acquisition and conversion alike.
// RULE16 - Sampling switch opens when conversion starts and stays open.
// RULE17 - Each converter pin can be set analog or digital.
// RULE18 - Software configures everything, enables, then sets go.
// RULE19 - Software polls go or waits for done, then reads the result.
// RULE20 - Enable bit turns the converter on and off.
// RULE21 - While enabled, go reads one when busy and zero when idle.
// RULE22 - Channel field picks 0 to 10; other channels give full scale.
// RULE23 - Two bits choose negative and positive reference independently.
// RULE24 - Left: high byte plus two top low bits; right: low byte plus two bits.
// RULE25 - One result bit per bit period, most significant first.
// RULE26 - Go written while disabled starts nothing.
// RULE27 - Bit 6 of the third control register ignores writes, reads zero.
module adcsq_sequencer
  import adcsq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic              sleep_in,
  input  wire logic              rc_clk_in,
  input  wire logic              cmp_in,
  output logic [7:0]             rdata_out,
  output logic                   conv_enable_out,
  output logic                   sample_close_out,
  output logic [3:0]             channel_out,
  output logic                   neg_ref_pin_out,
  output logic                   pos_ref_pin_out,
  output logic [10:0]            analog_pin_en_out,
  output logic [9:0]             dac_code_out,
  output logic                   done_flag_out
);

  adcsq_state_e st;
  adcsq_state_e next_st;
  logic [4:0]   cnt;
  logic [4:0]   next_cnt;
  logic [9:0]   next_sar;
  logic         enable;
  logic         next_enable;
  logic         go;
  logic         next_go;
  logic [3:0]   channel;
  logic [3:0]   next_channel;
  logic [5:0]   ctrl_one;
  logic [5:0]   next_ctrl_one;
  logic         justify;
  logic         next_justify;
  logic [2:0]   acq_sel;
  logic [2:0]   next_acq_sel;
  logic [2:0]   clk_sel;
  logic [2:0]   next_clk_sel;
  logic         done_flag;
  logic         next_done_flag;
  logic         irq_enable;
  logic         next_irq_enable;
  logic [7:0]   result_high;
  logic [7:0]   next_result_high;
  logic [7:0]   result_low;
  logic [7:0]   next_result_low;
  logic [7:0]   next_rdata;
  logic [10:0]  next_analog;
  logic         next_sample;
  logic         tick;
  logic         run;
  logic         wr_zero;
  logic         start;
  logic         finish;
  logic [9:0]   final_code;
  logic [9:0]   load_code;
  logic [3:0]   bit_idx;

  assign wr_zero = wr_in && (addr_in == OFS_CTRL_ZERO);
  assign run     = (st == ST_ACQ) || (st == ST_CONV) || (st == ST_WAIT);
  assign start   = (st == ST_IDLE) && go && enable;
  assign finish  = (st == ST_CONV) && tick && (cnt == CONV_LAST_TAD);
  assign bit_idx = 4'(CONV_LAST_TAD - cnt);

  adcsq_tad_tick u_tick (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .clk_sel_in (clk_sel),
    .run_in     (run),
    .sleep_in   (sleep_in),
    .rc_clk_in  (rc_clk_in),
    .tick_out   (tick)
  ); // RULE3 RULE6

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: start, optional RC hold, acquisition, conversion, recovery.
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_sar = dac_code_out;
    final_code = dac_code_out;
    // The comparator answers the registered trial code within a cycle, so it is not
    // synchronised: two more flops would outlast the two-clock bit period.
    if (st == ST_CONV && !cmp_in && cnt != 5'h00) begin
      final_code[bit_idx] = 1'b0; // RULE7
    end
    case (st)
      ST_IDLE: begin
        next_cnt = 5'h00;
        if (start) begin
          next_sar = SAR_FIRST;
          if (is_rc(clk_sel)) begin
            next_st = ST_DELAY; // RULE4
          end else if (acq_sel != 3'h0) begin
            next_st = ST_ACQ; // RULE13
          end else begin
            next_st = ST_CONV; // RULE12
          end
        end
      end
      ST_DELAY: begin
        next_cnt = cnt + 5'h01;
        if (cnt == RC_HOLD_CLKS - 5'h01) begin
          next_cnt = 5'h00;
          next_st  = (acq_sel != 3'h0) ? ST_ACQ : ST_CONV; // RULE4
        end
      end
      ST_ACQ: begin
        if (tick) begin
          next_cnt = cnt + 5'h01;
          if (cnt + 5'h01 == acq_tads(acq_sel)) begin
            next_cnt = 5'h00;
            next_st  = ST_CONV; // RULE2 RULE13
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          next_cnt = cnt + 5'h01;
          next_sar = final_code; // RULE25
          if (cnt != 5'h00 && bit_idx != 4'h0) begin
            next_sar[bit_idx - 4'h1] = 1'b1;
          end
          if (finish) begin
            next_cnt = 5'h00;
            next_st  = ST_WAIT; // RULE11
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          next_cnt = cnt + 5'h01;
          if (cnt + 5'h01 == RECOVER_TADS) begin
            next_cnt = 5'h00;
            next_st  = ST_IDLE; // RULE11 RULE14
          end
        end
      end
      default: begin
        next_st  = ST_IDLE;
        next_cnt = 5'h00;
      end
    endcase
    // Clearing go mid-flight aborts without a result; recovery still applies.
    if (wr_zero && !wdata_in[BIT_GO] && (st == ST_ACQ || st == ST_CONV || st == ST_DELAY)) begin
      next_st  = ST_WAIT;
      next_cnt = 5'h00;
    end
    if (!enable || (wr_zero && !wdata_in[BIT_ENABLE])) begin
      next_st  = ST_IDLE; // RULE20
      next_cnt = 5'h00;
    end
    // Switch opens once the conversion phase is entered, or while the RC clock is held with acquisition zero.
    next_sample = (next_enable && (next_st == ST_IDLE || next_st == ST_ACQ)) ||
                  (next_enable && next_st == ST_DELAY && acq_sel != 3'h0); // RULE16
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and hardware updates.
  always_comb begin
    next_enable      = enable;
    next_go          = go;
    next_channel     = channel;
    next_ctrl_one    = ctrl_one;
    next_justify     = justify;
    next_acq_sel     = acq_sel;
    next_clk_sel     = clk_sel;
    next_done_flag   = done_flag;
    next_irq_enable  = irq_enable;
    next_result_high = result_high;
    next_result_low  = result_low;
    load_code = (channel > LAST_CHANNEL) ? FULL_SCALE : final_code; // RULE22
    if (wr_in) begin
      case (addr_in)
        OFS_CTRL_ZERO: begin
          next_enable  = wdata_in[BIT_ENABLE]; // RULE20
          next_channel = wdata_in[POS_CHANNEL +: 4];
          // The enable bit already stored gates go, so one write cannot do both.
          next_go = wdata_in[BIT_GO] && enable && wdata_in[BIT_ENABLE]; // RULE26
        end
        OFS_CTRL_ONE: begin
          next_ctrl_one = wdata_in[5:0]; // RULE5 RULE17 RULE23
        end
        OFS_CTRL_TWO: begin
          next_justify = wdata_in[BIT_JUSTIFY]; // RULE1 RULE27
          next_acq_sel = wdata_in[POS_ACQ_SEL +: 3];
          next_clk_sel = wdata_in[POS_CLK_SEL +: 3];
        end
        OFS_RESULT_HIGH: next_result_high = wdata_in;
        OFS_RESULT_LOW:  next_result_low  = wdata_in;
        OFS_DONE_STATUS: begin
          next_done_flag  = wdata_in[BIT_DONE_FLAG];
          next_irq_enable = wdata_in[BIT_IRQ_ENABLE];
        end
        default: begin
          next_enable = enable;
        end
      endcase
    end
    if (finish) begin
      next_go        = 1'b0; // RULE9
      next_done_flag = 1'b1; // RULE9
      if (justify) begin
        next_result_high = {6'h00, load_code[9:8]}; // RULE24
        next_result_low  = load_code[7:0];
      end else begin
        next_result_high = load_code[9:2]; // RULE24
        next_result_low  = {load_code[1:0], 6'h00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port and pin decode.
  always_comb begin
    next_rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        OFS_CTRL_ZERO:   next_rdata = {2'h0, channel, go, enable}; // RULE21
        OFS_CTRL_ONE:    next_rdata = {2'h0, ctrl_one};
        OFS_CTRL_TWO:    next_rdata = {justify, 1'b0, acq_sel, clk_sel}; // RULE27
        OFS_RESULT_HIGH: next_rdata = result_high;
        OFS_RESULT_LOW:  next_rdata = result_low;
        OFS_DONE_STATUS: next_rdata = {6'h00, irq_enable, done_flag};
        default:         next_rdata = 8'h00;
      endcase
    end
    // Codes up to four leave every pin analog; higher codes turn pins digital from the top.
    next_analog = 11'h7FF;
    if (ctrl_one[3:0] > 4'h4) begin
      next_analog = 11'h7FF >> (ctrl_one[3:0] - 4'h4); // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st                <= ST_IDLE; // RULE8
      cnt               <= 5'h00;
      dac_code_out      <= 10'h000;
      enable            <= RST_CTRL_ZERO[BIT_ENABLE];
      go                <= RST_CTRL_ZERO[BIT_GO];
      channel           <= RST_CTRL_ZERO[POS_CHANNEL +: 4];
      ctrl_one          <= RST_CTRL_ONE[5:0];
      justify           <= RST_CTRL_TWO[BIT_JUSTIFY];
      acq_sel           <= RST_CTRL_TWO[POS_ACQ_SEL +: 3];
      clk_sel           <= RST_CTRL_TWO[POS_CLK_SEL +: 3];
      done_flag         <= RST_DONE_STATUS[BIT_DONE_FLAG];
      irq_enable        <= RST_DONE_STATUS[BIT_IRQ_ENABLE];
      rdata_out         <= 8'h00;
      conv_enable_out   <= 1'b0;
      sample_close_out  <= 1'b0;
      channel_out       <= 4'h0;
      neg_ref_pin_out   <= 1'b0;
      pos_ref_pin_out   <= 1'b0;
      analog_pin_en_out <= 11'h7FF;
      done_flag_out     <= 1'b0;
    end else begin
      st                <= next_st;
      cnt               <= next_cnt;
      dac_code_out      <= next_sar;
      enable            <= next_enable;
      go                <= next_go;
      channel           <= next_channel;
      ctrl_one          <= next_ctrl_one;
      justify           <= next_justify;
      acq_sel           <= next_acq_sel;
      clk_sel           <= next_clk_sel;
      done_flag         <= next_done_flag;
      irq_enable        <= next_irq_enable;
      rdata_out         <= next_rdata;
      conv_enable_out   <= next_enable;
      sample_close_out  <= next_sample;
      channel_out       <= next_channel;
      neg_ref_pin_out   <= next_ctrl_one[BIT_NEG_REF]; // RULE23
      pos_ref_pin_out   <= next_ctrl_one[BIT_POS_REF]; // RULE23
      analog_pin_en_out <= next_analog;
      done_flag_out     <= next_done_flag;
    end
  end

  // The result pair sits outside any reset so its contents survive one.
  always_ff @(posedge clk_in) begin
    result_high <= next_result_high; // RULE10
    result_low  <= next_result_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_rc_start;
    start && is_rc(clk_sel);
  endsequence

  sequence s_rc_hold;
    (st == ST_DELAY && !run) [*4];
  endsequence

  sequence s_finish_right;
    finish && justify;
  endsequence

  rc_hold_a: assert property (s_rc_start |=> s_rc_hold) // RULE4
    else $error("RC clock start was not held for one instruction cycle.");

  go_disabled_a: assert property (wr_zero && !enable |=> !go) // RULE26
    else $error("Go was set while the converter was disabled.");

  acq_zero_a: assert property (start && acq_sel == 3'h0 && !is_rc(clk_sel)
                               |=> st == ST_CONV && !sample_close_out) // RULE12
    else $error("Zero acquisition did not convert at once.");

  done_sets_a: assert property (finish |=> done_flag && !go && st == ST_WAIT) // RULE9
    else $error("Completion did not clear go and set the done flag.");

  justify_right_a: assert property (s_finish_right |=> result_high[7:2] == 6'h00) // RULE24
    else $error("Right justified result has high bits set.");

  justify_left_a: assert property (finish && !justify |=> result_low[5:0] == 6'h00) // RULE24
    else $error("Left justified result has low bits set.");

  recover_min_a: assert property (st == ST_WAIT && next_st == ST_IDLE && enable && !wr_zero
                                  |-> cnt == 5'h01 && tick) // RULE11
    else $error("Recovery ended before two bit periods.");

  conv_open_a: assert property (st == ST_CONV |-> !sample_close_out) // RULE16
    else $error("Sampling switch closed during conversion.");

  busy_go_a: assert property ((st == ST_ACQ || st == ST_CONV) && enable |-> go) // RULE15 RULE21
    else $error("Go flag dropped while busy.");

  resample_a: assert property (st == ST_WAIT ##1 st == ST_IDLE && enable
                               |-> sample_close_out) // RULE14
    else $error("Sampling did not resume after recovery.");

  fullscale_a: assert property (finish && justify && channel > LAST_CHANNEL
                                |=> {result_high[1:0], result_low} == FULL_SCALE) // RULE22
    else $error("Unused channel did not give full scale.");

endmodule

// ### test/tb.sv
// Purpose: Self-checking bench of the converter sequencer, driven over its register port.
// Assumes: Core clock 100 MHz; a comparator model follows the trial code against a target.
// Notes:   The RC clock runs free, as an on-chip oscillator does, with every fifth edge on a core clock edge.
module tb
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in;
  logic              rst_b_in;
  logic [ADDR_W-1:0] addr_in;
  logic [7:0]        wdata_in;
  logic              wr_in;
  logic              rd_in;
  logic              sleep_in;
  logic              rc_clk_in;
  logic              cmp_in;
  logic [7:0]        rdata_out;
  logic              conv_enable_out;
  logic              sample_close_out;
  logic [3:0]        channel_out;
  logic              neg_ref_pin_out;
  logic              pos_ref_pin_out;
  logic [10:0]       analog_pin_en_out;
  logic [9:0]        dac_code_out;
  logic              done_flag_out;
  logic [9:0]        target;
  logic [15:0]       last_pair;
  logic [7:0]        v;
  int                mismatches;
  int                n_checks;
  int                acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adcsq_sequencer u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .sleep_in(sleep_in),
    .rc_clk_in(rc_clk_in), .cmp_in(cmp_in), .rdata_out(rdata_out),
    .conv_enable_out(conv_enable_out), .sample_close_out(sample_close_out),
    .channel_out(channel_out), .neg_ref_pin_out(neg_ref_pin_out),
    .pos_ref_pin_out(pos_ref_pin_out), .analog_pin_en_out(analog_pin_en_out),
    .dac_code_out(dac_code_out), .done_flag_out(done_flag_out));

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk_in = ~clk_in;
  // The half period of 83 ns lands every fifth RC edge on a core clock edge; the rest fall between.
  always #83 rc_clk_in = ~rc_clk_in;
  always @(posedge clk_in) cmp_in <= (target >= dac_code_out);

  function automatic int div_exp(input logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h1: return 8;
      3'h2: return 32;
      3'h4: return 4;
      3'h5: return 16;
      3'h6: return 64;
      default: return 0;
    endcase
  endfunction

  // Pin i stays analog while i plus the port code is below fifteen.
  function automatic logic [10:0] analog_exp(input logic [3:0] c);
    for (int i = 0; i < 11; i++) begin
      analog_exp[i] = (i + int'(c)) < 15;
    end
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic wait_for(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic convert(input logic [3:0] ch, input logic [7:0] c2, input logic [9:0] tgt);
    logic [7:0] hi;
    logic [7:0] lo;
    logic [9:0] code;
    int         div;
    int         acq;
    int         n;
    time        t0;
    div  = div_exp(c2[2:0]);
    acq  = acq_tab[c2[5:3]];
    code = (ch > LAST_CHANNEL) ? FULL_SCALE : tgt;
    target <= tgt;
    wr(OFS_CTRL_TWO, c2);
    wr(OFS_CTRL_ZERO, {2'b00, ch, 2'b01});
    // Registered outputs take the write only after the edge that stores it.
    #1;
    chk("channel", 16'(channel_out), 16'(ch));
    chk("enable", 16'(conv_enable_out), 16'h0001);
    wr(OFS_CTRL_ZERO, {2'b00, ch, 2'b11});
    t0 = $time;
    rd(OFS_CTRL_ZERO, hi);
    chk("busy go", 16'(hi[BIT_GO]), 16'h0001);
    if (acq == 0) chk("sample at go", 16'(sample_close_out), 16'h0000);
    else if (acq * div >= 8) chk("sample acq", 16'(sample_close_out), 16'h0001);
    wait_for(done_flag_out, 20000, n);
    n = int'(($time - t0) / 10);
    chk("done", 16'(done_flag_out), 16'h0001);
    chk("sample open", 16'(sample_close_out), 16'h0000);
    if (div > 0) begin
      chk("conv time", 16'(n >= (acq + 11) * div && n <= (acq + 11) * div + 12), 16'h0001);
    end
    wait_for(sample_close_out, 3000, n);
    chk("resume", 16'(sample_close_out), 16'h0001);
    chk("recovery", 16'(n >= 2 * div - 2), 16'h0001);
    rd(OFS_RESULT_HIGH, hi);
    rd(OFS_RESULT_LOW, lo);
    last_pair = c2[BIT_JUSTIFY] ? {6'h00, code} : {code, 6'h00};
    chk("result", {hi, lo}, last_pair);
    rd(OFS_CTRL_ZERO, hi);
    chk("go cleared", 16'(hi[BIT_GO]), 16'h0000);
    wr(OFS_DONE_STATUS, 8'h00);
    rd(OFS_DONE_STATUS, lo);
    chk("done cleared", 16'(lo), 16'h0000);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    int n;
    logic [7:0] r;
    clk_in = 0; rc_clk_in = 0; rst_b_in = 0; addr_in = 0; wdata_in = 0;
    wr_in = 0; rd_in = 0; sleep_in = 0; cmp_in = 0; target = 0;
    void'($urandom(32'hDFDCAA5E));
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), r);
      if (a != 3 && a != 4) chk("reset value", 16'(r), 16'h0000);
    end
    chk("pins analog", 16'(analog_pin_en_out), 16'h07FF);
    wr(OFS_CTRL_ZERO, 8'h02);
    rd(OFS_CTRL_ZERO, r);
    chk("go while off", 16'(r), 16'h0000);
    wr(OFS_CTRL_TWO, 8'hFF);
    rd(OFS_CTRL_TWO, r);
    chk("ctrl two", 16'(r), 16'h00BF);
    r = 8'($urandom());
    wr(OFS_CTRL_ONE, r);
    rd(OFS_CTRL_ONE, v);
    chk("ctrl one", 16'(v), 16'(r & 8'h3F));
    chk("refs", 16'({neg_ref_pin_out, pos_ref_pin_out}), 16'(r[5:4]));
    chk("pins cfg", 16'(analog_pin_en_out), 16'(analog_exp(r[3:0])));
    // Every clock code once; the RC codes run with the device asleep.
    for (int k = 0; k < 8; k++) begin
      sleep_in <= (k[1:0] == 2'b11);
      convert(4'($urandom_range(10)), {1'($urandom()), 1'b0, 3'($urandom()), 3'(k)},
              10'($urandom()));
    end
    sleep_in <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      convert(4'(k), {1'($urandom()), 1'b0, 3'(k), 3'h0},
              (k == 0) ? 10'h000 : (k == 7) ? 10'h3FF : 10'($urandom()));
    end
    repeat (4) convert(4'($urandom()), {1'($urandom()), 4'h0, 3'($urandom_range(2))},
                       10'($urandom()));
    // A core-derived bit clock stops in sleep, so the conversion must stall.
    wr(OFS_CTRL_TWO, 8'h00);
    sleep_in <= 1'b1;
    wr(OFS_CTRL_ZERO, 8'h03);
    repeat (100) @(posedge clk_in);
    rd(OFS_CTRL_ZERO, r);
    chk("stalled", 16'({r[BIT_GO], done_flag_out}), 16'h0002);
    sleep_in <= 1'b0;
    wait_for(done_flag_out, 500, n);
    chk("unstalled", 16'(done_flag_out), 16'h0001);
    wait_for(sample_close_out, 500, n);
    wr(OFS_DONE_STATUS, 8'h00);
    target <= 10'h155;
    convert(4'h1, 8'h80, 10'h2AA);
    wr(OFS_CTRL_TWO, 8'h06);
    wr(OFS_CTRL_ZERO, 8'h07);
    repeat (50) @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rd(OFS_CTRL_ZERO, r);
    chk("abort", 16'({r, conv_enable_out, done_flag_out}), 16'h0000);
    rd(OFS_RESULT_HIGH, r);
    chk("result kept", 16'(r), 16'(last_pair[15:8]));
    repeat (2000) @(posedge clk_in);
    chk("no late done", 16'(done_flag_out), 16'h0000);
    report_and_stop();
  end
endmodule
